// File: rtl/torque_command_block.sv
// Purpose: torque mode command handshake for one servo axis
// Assumes: drive inputs synchronous to core_clk_in
// Notes: state advances only on control cycle ticks
//
// Operation
// - axis 1..32, taken when enable rises
// - start only on enable rising edge
// - setpoint signed per-mille, default zero
// - setpoint changes apply while enable high
// - sign of setpoint sets torque direction
// - torque mode while command executes
// - only stop may preempt execution
// - enable low ends command, frees axis
// - busy, then active, then reached
// - active from first controlling cycle
// - enable fall clears busy, active, reached
// - stop sets preempted, clears others
// - illegal axis gives error one cycle later
// - error clears reached, busy, active
// - enable fall clears error and code

module torque_command_block #(
  parameter int unsigned CYCLE_CLKS = torque_pkg::CYCLE_CLKS
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic torque_attained_in,
  input wire logic drive_fault_in,
  input wire logic motion_req_in,
  output logic motion_grant_out,
  output logic busy_out,
  output logic active_out,
  output logic torque_reached_out,
  output logic preempted_flag_out,
  output logic error_out,
  output logic [15:0] fault_code_out,
  output logic [5:0] axis_out,
  output logic torque_mode_out,
  output logic signed [15:0] torque_cmd_out,
  output logic torque_pos_out,
  output logic torque_neg_out,
  output logic cycle_tick_out,
  output logic irq_out
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic en;
    logic [5:0] axis_req;
    logic signed [15:0] setpoint;
    logic stop_pend;
    logic en_prev;
    torque_pkg::state_t st;
    logic [5:0] axis;
    logic busy;
    logic active;
    logic reached;
    logic preempted;
    logic error;
    logic [15:0] fault;
    logic signed [15:0] torque;
    logic pos;
    logic neg;
    logic [31:0] rdata;
  } core_t;

  core_t s;
  core_t next_s;
  logic tick;
  logic rise;
  logic fall;
  logic stop_now;
  logic [torque_pkg::EVT_W-1:0] evt;
  localparam logic signed [15:0] SP_ZERO = torque_pkg::SP_RESET;


  torque_irq_if irq_bus ();

  // states in which the axis belongs to this command
  function automatic logic is_exec(input torque_pkg::state_t st);
    return (st == torque_pkg::ST_START) || (st == torque_pkg::ST_RAMP) ||
           (st == torque_pkg::ST_HOLD);
  endfunction

  function automatic logic axis_ok(input logic [5:0] ax);
    return (ax >= torque_pkg::AXIS_MIN) && (ax <= torque_pkg::AXIS_MAX);
  endfunction

  // ****************************************************
  // submodules
  // ****************************************************
  torque_cycle_tick #(
    .CYCLE_CLKS(CYCLE_CLKS)
  ) u_tick (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .tick_out(tick)
  );

  torque_irq u_irq (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .bus(irq_bus.sink)
  );

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    next_s = s;
    evt = '0;
    rise = s.en & ~s.en_prev;
    fall = ~s.en & s.en_prev;
    stop_now = s.stop_pend;

    // register writes
    if (wr_in) begin
      case (addr_in)
        torque_pkg::OFS_CTRL: begin
          next_s.en = wdata_in[torque_pkg::CTRL_EN_BIT];
          next_s.axis_req = wdata_in[torque_pkg::CTRL_AXIS_LSB +: torque_pkg::AXIS_W];
        end
        torque_pkg::OFS_SETPOINT: begin
          next_s.setpoint = wdata_in[torque_pkg::SP_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // stop request held until the next tick; a new write wins over the consume
    if (tick) begin
      next_s.stop_pend = 1'b0;
    end
    if (wr_in && (addr_in == torque_pkg::OFS_STOP) && wdata_in[torque_pkg::STOP_BIT]) begin
      next_s.stop_pend = 1'b1;
    end

    // register reads, data valid the cycle after the strobe
    next_s.rdata = 32'h0;
    if (rd_in) begin
      case (addr_in)
        torque_pkg::OFS_CTRL: begin
          next_s.rdata[torque_pkg::CTRL_EN_BIT] = s.en;
          next_s.rdata[torque_pkg::CTRL_AXIS_LSB +: torque_pkg::AXIS_W] = s.axis_req;
        end
        torque_pkg::OFS_SETPOINT: begin
          next_s.rdata[torque_pkg::SP_W-1:0] = s.setpoint;
        end
        torque_pkg::OFS_STATUS: begin
          next_s.rdata[4:0] = {s.error, s.preempted, s.reached, s.active, s.busy};
          next_s.rdata[7:5] = s.st;
          next_s.rdata[torque_pkg::CTRL_AXIS_LSB +: torque_pkg::AXIS_W] = s.axis;
          next_s.rdata[torque_pkg::STAT_FAULT_LSB +: torque_pkg::FAULT_W] = s.fault;
        end
        torque_pkg::OFS_IRQ_STATUS: begin
          next_s.rdata[torque_pkg::EVT_W-1:0] = irq_bus.status;
        end
        torque_pkg::OFS_IRQ_ENABLE: begin
          next_s.rdata[torque_pkg::EVT_W-1:0] = irq_bus.enable;
        end
        default: begin
        end
      endcase
    end

    // control cycle step
    if (tick) begin
      next_s.en_prev = s.en;
      case (s.st)
        torque_pkg::ST_IDLE: begin
          if (rise) begin
            next_s.busy = 1'b1;
            next_s.axis = s.axis_req;
            next_s.st = torque_pkg::ST_START;
            evt[torque_pkg::EVT_START] = 1'b1;
          end
        end
        torque_pkg::ST_START, torque_pkg::ST_RAMP, torque_pkg::ST_HOLD: begin
          if (stop_now) begin
            // only the stop command preempts; a late stop flags for one cycle
            next_s.preempted = 1'b1;
            next_s.busy = 1'b0;
            next_s.active = 1'b0;
            next_s.reached = 1'b0;
            next_s.st = torque_pkg::ST_ABORT;
            evt[torque_pkg::EVT_PREEMPT] = 1'b1;
            evt[torque_pkg::EVT_RELEASE] = 1'b1;
          end else if (fall) begin
            next_s.busy = 1'b0;
            next_s.active = 1'b0;
            next_s.reached = 1'b0;
            next_s.st = torque_pkg::ST_IDLE;
            evt[torque_pkg::EVT_RELEASE] = 1'b1;
          end else if ((s.st == torque_pkg::ST_START && !axis_ok(s.axis)) ||
                       drive_fault_in) begin
            next_s.error = 1'b1;
            next_s.fault = (s.st == torque_pkg::ST_START && !axis_ok(s.axis)) ?
                           torque_pkg::FAULT_AXIS : torque_pkg::FAULT_EXEC;
            next_s.busy = 1'b0;
            next_s.active = 1'b0;
            next_s.reached = 1'b0;
            next_s.st = torque_pkg::ST_FAULT;
            evt[torque_pkg::EVT_ERROR] = 1'b1;
            evt[torque_pkg::EVT_RELEASE] = 1'b1;
          end else if (s.st == torque_pkg::ST_START) begin
            next_s.active = 1'b1;
            next_s.st = torque_pkg::ST_RAMP;
          end else if (s.st == torque_pkg::ST_RAMP) begin
            if (torque_attained_in) begin
              // busy and active stay high with reached
              next_s.reached = 1'b1;
              next_s.st = torque_pkg::ST_HOLD;
              evt[torque_pkg::EVT_REACHED] = 1'b1;
            end
          end else begin
            if (!torque_attained_in) begin
              next_s.reached = 1'b0;
              next_s.st = torque_pkg::ST_RAMP;
            end
          end
        end
        torque_pkg::ST_FAULT: begin
          if (!s.en) begin
            next_s.error = 1'b0;
            next_s.fault = torque_pkg::FAULT_NONE;
            next_s.st = torque_pkg::ST_IDLE;
          end
        end
        torque_pkg::ST_ABORT: begin
          if (!s.en) begin
            next_s.preempted = 1'b0;
            next_s.st = torque_pkg::ST_IDLE;
          end
        end
        default: begin
          next_s.st = torque_pkg::ST_IDLE;
        end
      endcase

      // torque follows the live setpoint while the axis is controlled
      if (next_s.st == torque_pkg::ST_RAMP || next_s.st == torque_pkg::ST_HOLD) begin
        next_s.torque = s.setpoint;
        next_s.pos = ~s.setpoint[torque_pkg::SP_W-1] && (s.setpoint != SP_ZERO);
        next_s.neg = s.setpoint[torque_pkg::SP_W-1];
      end else begin
        next_s.torque = SP_ZERO;
        next_s.pos = 1'b0;
        next_s.neg = 1'b0;
      end
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '{
        en: 1'b0,
        axis_req: torque_pkg::AXIS_RESET,
        setpoint: torque_pkg::SP_RESET,
        stop_pend: 1'b0,
        en_prev: 1'b0,
        st: torque_pkg::ST_IDLE,
        axis: torque_pkg::AXIS_RESET,
        busy: 1'b0,
        active: 1'b0,
        reached: 1'b0,
        preempted: 1'b0,
        error: 1'b0,
        fault: torque_pkg::FAULT_NONE,
        torque: torque_pkg::SP_RESET,
        pos: 1'b0,
        neg: 1'b0,
        rdata: 32'h0
      };
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************
  // interrupt link
  // ****************************************************
  assign irq_bus.evt = evt;
  assign irq_bus.clr = (wr_in && addr_in == torque_pkg::OFS_IRQ_CLEAR) ?
                       wdata_in[torque_pkg::EVT_W-1:0] : '0;
  assign irq_bus.en_we = wr_in && (addr_in == torque_pkg::OFS_IRQ_ENABLE);
  assign irq_bus.en_wdata = wdata_in[torque_pkg::EVT_W-1:0];

  // ****************************************************
  // outputs
  // ****************************************************
  assign rdata_out = s.rdata;
  assign busy_out = s.busy;
  assign active_out = s.active;
  assign torque_reached_out = s.reached;
  assign preempted_flag_out = s.preempted;
  assign error_out = s.error;
  assign fault_code_out = s.fault;
  assign axis_out = s.axis;
  assign torque_mode_out = is_exec(s.st);
  assign motion_grant_out = motion_req_in && !is_exec(s.st);
  assign torque_cmd_out = s.torque;
  assign torque_pos_out = s.pos;
  assign torque_neg_out = s.neg;
  assign cycle_tick_out = tick;
  assign irq_out = irq_bus.irq;

endmodule // torque_command_block

// File: include/torque_pkg.sv
// Purpose: shared constants and types of the torque command block
// Assumes: 50 MHz core clock, one control cycle per tick
// Notes: offsets are byte addresses of 32-bit words

// ****************************************************
// package
// ****************************************************
package torque_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SETPOINT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_STOP = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AXIS_LSB = 8;
  localparam int AXIS_W = 6;
  localparam int SP_W = 16;
  localparam int FAULT_W = 16;
  localparam int STAT_FAULT_LSB = 16;
  localparam int STOP_BIT = 0;

  // reset values and limits
  localparam logic [5:0] AXIS_MIN = 6'h01;
  localparam logic [5:0] AXIS_MAX = 6'h20;
  localparam logic [5:0] AXIS_RESET = 6'h00;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_AXIS = 16'h0001;
  localparam logic [15:0] FAULT_EXEC = 16'h0002;

  // events
  localparam int EVT_W = 5;
  localparam int EVT_START = 0;
  localparam int EVT_REACHED = 1;
  localparam int EVT_PREEMPT = 2;
  localparam int EVT_ERROR = 3;
  localparam int EVT_RELEASE = 4;
  localparam logic [4:0] EVT_RESET = 5'h00;

  // control cycle timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CYCLE_MS = 1;
  localparam int CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_RAMP = 3'h3,
    ST_HOLD = 3'h2,
    ST_FAULT = 3'h6,
    ST_ABORT = 3'h7
  } state_t;

endpackage

// File: include/torque_irq_if.sv
// Purpose: carries events and interrupt registers between core and irq block
// Assumes: single clock domain
// Notes: evt and clr are one-cycle pulses

// ****************************************************
// interface
// ****************************************************
interface torque_irq_if;
  logic [torque_pkg::EVT_W-1:0] evt;
  logic [torque_pkg::EVT_W-1:0] clr;
  logic [torque_pkg::EVT_W-1:0] en_wdata;
  logic en_we;
  logic [torque_pkg::EVT_W-1:0] status;
  logic [torque_pkg::EVT_W-1:0] enable;
  logic irq;

  modport core (output evt, output clr, output en_wdata, output en_we,
                input status, input enable, input irq);
  modport sink (input evt, input clr, input en_wdata, input en_we,
                output status, output enable, output irq);
endinterface

// File: rtl/torque_cycle_tick.sv
// Purpose: control cycle strobe generator
// Assumes: CYCLE_CLKS of at least 1
// Notes: tick is a one-clock pulse at the end of each control cycle

module torque_cycle_tick #(
  parameter int unsigned CYCLE_CLKS = torque_pkg::CYCLE_CLKS
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  output logic tick_out
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tick_t;

  tick_t s;
  tick_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt >= 32'(CYCLE_CLKS - 1)) begin
      next_s.cnt = 32'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_out = s.tick;

endmodule // torque_cycle_tick

// File: rtl/torque_irq.sv
// Purpose: sticky event status, enable mask and interrupt level
// Assumes: events and clears are one-cycle pulses
// Notes: a set in the clearing cycle wins

module torque_irq (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  torque_irq_if.sink bus
);

  typedef struct packed {
    logic [torque_pkg::EVT_W-1:0] status;
    logic [torque_pkg::EVT_W-1:0] enable;
  } irq_t;

  irq_t s;
  irq_t next_s;

  always_comb begin
    next_s = s;
    for (int i = 0; i < torque_pkg::EVT_W; i++) begin
      next_s.status[i] = (s.status[i] & ~bus.clr[i]) | bus.evt[i];
    end
    if (bus.en_we) begin
      next_s.enable = bus.en_wdata;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '{status: torque_pkg::EVT_RESET, enable: torque_pkg::EVT_RESET};
    end else begin
      s <= next_s;
    end
  end

  assign bus.status = s.status;
  assign bus.enable = s.enable;
  assign bus.irq = |(s.status & s.enable);

endmodule // torque_irq

// File: test/torque_cmd_checker.sv
// Purpose: port-level assertions of the torque command block
// Assumes: outputs move only around control cycle ticks
// Notes: bound into torque_command_block below

// ******
// checker
// ******
module torque_cmd_checker #(
  parameter int unsigned CYCLE_CLKS = torque_pkg::CYCLE_CLKS
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic motion_grant_out,
  input wire logic busy_out,
  input wire logic active_out,
  input wire logic torque_reached_out,
  input wire logic preempted_flag_out,
  input wire logic error_out,
  input wire logic [15:0] fault_code_out,
  input wire logic [5:0] axis_out,
  input wire logic torque_mode_out,
  input wire logic signed [15:0] torque_cmd_out,
  input wire logic torque_pos_out,
  input wire logic torque_neg_out,
  input wire logic cycle_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] flags;
  assign flags = {busy_out, active_out, torque_reached_out, preempted_flag_out, error_out};

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  // no tick in the last two clocks
  sequence quiet_s;
    !$past(cycle_tick_out) && !$past(cycle_tick_out, 2);
  endsequence
  sequence start_s;
    $rose(busy_out) && !error_out;
  endsequence
  // active comes one control cycle after busy
  property active_late_p;
    $rose(active_out) |-> busy_out && $past(busy_out, CYCLE_CLKS);
  endproperty

  hold_ticks_a: assert property (quiet_s |-> $stable({flags, fault_code_out}))
    else $error("flags moved between control cycles");
  busy_first_a: assert property (start_s |-> !active_out && !torque_reached_out)
    else $error("busy did not lead the start");
  active_late_a: assert property (active_late_p)
    else $error("active rose without a cycle of busy");
  reach_keeps_a: assert property (torque_reached_out |-> busy_out && active_out)
    else $error("reached without busy and active");
  error_clears_a: assert property ($rose(error_out) |-> flags[4:2] == 3'h0)
    else $error("error left busy, active or reached");
  preempt_clears_a: assert property ($rose(preempted_flag_out) |-> flags[4:2] == 3'h0)
    else $error("preempt left busy, active or reached");
  fault_pair_a: assert property (error_out == (fault_code_out != 16'h0000))
    else $error("fault code and error disagree");
  axis_bad_a: assert property (error_out && fault_code_out == torque_pkg::FAULT_AXIS |->
    axis_out == 6'h00 || axis_out > 6'h20)
    else $error("axis fault on a legal axis");
  grant_block_a: assert property (busy_out || active_out |-> !motion_grant_out)
    else $error("other motion granted while executing");
  sign_dir_a: assert property (torque_pos_out == (torque_cmd_out > 0) &&
    torque_neg_out == (torque_cmd_out < 0))
    else $error("torque direction wrong");
  idle_cmd_a: assert property (!active_out |-> torque_cmd_out == 16'sh0000)
    else $error("torque commanded while not active");
  mode_active_a: assert property (active_out |-> torque_mode_out)
    else $error("active outside torque mode");
endmodule // torque_cmd_checker

bind torque_command_block torque_cmd_checker #(.CYCLE_CLKS(CYCLE_CLKS)) u_torque_chk (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .motion_grant_out(motion_grant_out),
  .busy_out(busy_out), .active_out(active_out), .torque_reached_out(torque_reached_out),
  .preempted_flag_out(preempted_flag_out), .error_out(error_out),
  .fault_code_out(fault_code_out), .axis_out(axis_out), .torque_mode_out(torque_mode_out),
  .torque_cmd_out(torque_cmd_out), .torque_pos_out(torque_pos_out),
  .torque_neg_out(torque_neg_out), .cycle_tick_out(cycle_tick_out)
);

// File: test/servo_drive_model.sv
// Purpose: servo drive seen by the torque command block
// Assumes: drive powered and enabled throughout
// Notes: slow mode delays torque attainment by some cycles

// ******
// drive model
// ******
module servo_drive_model (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic torque_mode_in,
  input wire logic slow_in,
  input wire logic fault_req_in,
  output logic torque_attained_out,
  output logic drive_fault_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int lag;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lag <= 0;
    end else if (!torque_mode_in) begin
      lag <= 0;
    end else if (lag < 64) begin
      lag <= lag + 1;
    end
  end
  // answers only while in torque mode
  assign torque_attained_out = torque_mode_in && (lag >= (slow_in ? 9 : 1));
  assign drive_fault_out = fault_req_in && torque_mode_in;
endmodule // servo_drive_model

// File: test/testbench.sv
// Purpose: self-checking bench of the torque command block
// Assumes: four clocks per control cycle
// Notes: outputs sampled two clocks after each tick

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // signals
  // ******
  logic core_clk_in, arst_n_in, wr_in, rd_in, motion_req_in, motion_grant_out;
  logic torque_attained_in, drive_fault_in, busy_out, active_out, torque_reached_out;
  logic preempted_flag_out, error_out, torque_mode_out, torque_pos_out, torque_neg_out;
  logic cycle_tick_out, irq_out, slow, fault_req;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, rv;
  logic [15:0] fault_code_out;
  logic [5:0] axis_out;
  logic signed [15:0] torque_cmd_out;
  int err_total, checked, seed, ax, sp, req;
  int bad_axis[2] = '{0, 33};
  int exp_q[$];

  torque_command_block #(.CYCLE_CLKS(4)) DUT (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .torque_attained_in(torque_attained_in), .drive_fault_in(drive_fault_in),
    .motion_req_in(motion_req_in), .motion_grant_out(motion_grant_out),
    .busy_out(busy_out), .active_out(active_out), .torque_reached_out(torque_reached_out),
    .preempted_flag_out(preempted_flag_out), .error_out(error_out),
    .fault_code_out(fault_code_out), .axis_out(axis_out), .torque_mode_out(torque_mode_out),
    .torque_cmd_out(torque_cmd_out), .torque_pos_out(torque_pos_out),
    .torque_neg_out(torque_neg_out), .cycle_tick_out(cycle_tick_out), .irq_out(irq_out)
  );
  servo_drive_model drive (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .torque_mode_in(torque_mode_out), .slow_in(slow), .fault_req_in(fault_req),
    .torque_attained_out(torque_attained_in), .drive_fault_out(drive_fault_in));

  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  // ******
  // tasks
  // ******
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    rv = rdata_out;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk_in iff cycle_tick_out);
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask
  task automatic fl(input logic [4:0] e, input logic [15:0] f);
    chk({busy_out, active_out, torque_reached_out, preempted_flag_out, error_out}, e);
    chk(fault_code_out, f);
  endtask
  task automatic go(input int a, input int s);
    wr(torque_pkg::OFS_SETPOINT, s);
    wr(torque_pkg::OFS_CTRL, (a << 8) | 1);
    tk(1);
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ******
  // sequence
  // ******
  initial begin
    seed = 89;
    {addr_in, wdata_in, wr_in, rd_in, motion_req_in, slow, fault_req} = '0;
    arst_n_in = 1'b0;
    repeat (10) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    rd(torque_pkg::OFS_SETPOINT);
    chk(rv, 32'h0);
    rd(8'h1c);
    chk(rv, 32'h0);
    for (int i = 0; i < 3; i++) begin
      ax = 1 + ($unsigned($random(seed)) % 32);
      sp = $random(seed) % 1000;
      req = $random(seed) & 1;
      @(posedge core_clk_in);
      motion_req_in <= req[0];
      slow <= (i == 1);
      exp_q.push_back(sp);
      exp_q.push_back(-sp);
      go(ax, sp);
      fl(5'h10, 16'h0);
      chk(axis_out, ax);
      tk(1);
      fl(5'h18, 16'h0);
      chk(torque_cmd_out, exp_q.pop_front());
      chk({torque_pos_out, torque_neg_out}, {sp > 0, sp < 0});
      chk({motion_grant_out, torque_mode_out}, 2'b01);
      tk(1);
      fl({2'b11, i != 1, 2'b00}, 16'h0);
      wr(torque_pkg::OFS_SETPOINT, -sp);
      wr(torque_pkg::OFS_CTRL, (ax << 8) | 1);
      tk(1);
      chk(torque_cmd_out, exp_q.pop_front());
      fl(5'h1c, 16'h0);
      wr(torque_pkg::OFS_CTRL, 0);
      tk(1);
      fl(5'h00, 16'h0);
      chk({torque_cmd_out, motion_grant_out}, {16'h0, req[0]});
    end
    for (int late = 0; late < 2; late++) begin
      go(7, 30);
      tk(1);
      if (late) wr(torque_pkg::OFS_CTRL, 0);
      wr(torque_pkg::OFS_STOP, 1);
      tk(1);
      fl(5'h02, 16'h0);
      chk(torque_cmd_out, 0);
      if (!late) wr(torque_pkg::OFS_CTRL, 0);
      tk(1);
      fl(5'h00, 16'h0);
    end
    for (int i = 0; i < 2; i++) begin
      wr(torque_pkg::OFS_IRQ_ENABLE, i ? 0 : 8);
      go(bad_axis[i], 0);
      fl(5'h10, 16'h0);
      tk(1);
      fl(5'h01, torque_pkg::FAULT_AXIS);
      rd(torque_pkg::OFS_STATUS);
      chk(rv, {torque_pkg::FAULT_AXIS, 2'b00, 6'(bad_axis[i]), torque_pkg::ST_FAULT, 5'h10});
      rd(torque_pkg::OFS_IRQ_ENABLE);
      chk(rv, i ? 0 : 8);
      rd(torque_pkg::OFS_IRQ_STATUS);
      chk({irq_out, rv[3]}, {i == 0, 1'b1});
      wr(torque_pkg::OFS_IRQ_CLEAR, 8);
      rd(torque_pkg::OFS_IRQ_STATUS);
      chk(rv[3], 1'b0);
      wr(torque_pkg::OFS_CTRL, 0);
      tk(1);
      fl(5'h00, 16'h0);
      chk(irq_out, 1'b0);
    end
    go(3, 30);
    tk(2);
    fl(5'h1c, 16'h0);
    @(posedge core_clk_in);
    fault_req <= 1'b1;
    tk(1);
    fl(5'h01, torque_pkg::FAULT_EXEC);
    @(posedge core_clk_in);
    fault_req <= 1'b0;
    wr(torque_pkg::OFS_CTRL, 0);
    tk(1);
    fl(5'h00, 16'h0);
    final_report;
  end

  initial begin
    repeat (5000) @(posedge core_clk_in);
    err_total++;
    final_report;
  end
endmodule // testbench
